// [sba_addr_phase.sv]
`timescale 1ns/10ps
// What this block does
// - Eight internal interrupt request lines are delivered to the core, several pins may feed one.
// - After reset both duplicate pins feed line 1 and both duplicate pins feed line 7.
// - In external-master mode the block drives internal-master addresses and decodes external ones.
// - In internal-master mode the address pins carry the memory controller's memory address.
// - The owner of the address tenure holds the five transfer-type lines for the whole tenure.
// - The bus master drives the four transfer-size lines with the byte count of the transaction.
// - The bus master raises the burst flag for a four quad-word burst.
// - The initiator drives the global flag; the block drives it only for its own transactions.
// - A raised global flag marks the transfer for snooping, a low one marks it unsnooped.
// - The memory controller drives burst address bits 29 to 31 out to memory through one register stage.
// - The three shared pins serve either as burst address outputs or as requests 2, 3 and 5.
// - Each routed-in request pin reaches the core through its internal request line.
// - Pin function assignment is chosen by configuration loaded into the block.
module sba_addr_phase
  import sba_pkg::*;
#(
  parameter logic [ADDR_W-1:0] HIT_BASE = 32'h0000_0000,
  parameter logic [ADDR_W-1:0] HIT_MASK = 32'hFFF0_0000
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic                 bus_mode_ext,
  input  wire logic                 cfg_wr,
  input  wire sba_cfg_t             cfg_in,
  input  wire logic                 im_start,
  input  wire sba_xfer_t            im_xfer,
  input  wire logic                 im_end,
  output logic                      im_ack,
  input  wire logic                 mc_active,
  input  wire logic [ADDR_W-1:0]    mc_addr,
  input  wire logic [SHARED_W-1:0]  mc_burst_addr,
  input  wire logic                 ext_start,
  input  wire sba_xfer_t            bus_i,
  output sba_xfer_t                 bus_o,
  output logic                      addr_oe,
  output logic                      ctl_oe,
  output logic                      ext_hit,
  output logic                      ext_snoop,
  output sba_xfer_t                 ext_xfer,
  input  wire logic [DUP_W-1:0]     line1_pins_i,
  input  wire logic [DUP_W-1:0]     line7_pins_i,
  input  wire logic [SHARED_W-1:0]  shp_i,
  output logic [SHARED_W-1:0]       shp_o,
  output logic [SHARED_W-1:0]       shp_oe,
  input  wire logic [OTHER_W-1:0]   other_irq_i,
  output logic [IRQ_W-1:0]          int_req
);

  localparam int RAW_W = 2*DUP_W + SHARED_W + OTHER_W;

  if ((HIT_BASE & ~HIT_MASK) != '0) begin : g_bad_window
    $error("HIT_BASE has bits outside HIT_MASK");
  end

  typedef struct packed {
    sba_ten_t            ten;
    sba_cfg_t            cfg;
    logic [RAW_W-1:0]    sync1;
    logic [RAW_W-1:0]    sync2;
    logic [IRQ_W-1:0]    int_req;
    sba_xfer_t           bus_o;
    logic                addr_oe;
    logic                ctl_oe;
    logic                im_ack;
    logic                ext_hit;
    logic                ext_snoop;
    sba_xfer_t           ext_xfer;
    logic [SHARED_W-1:0] shp_o;
    logic [SHARED_W-1:0] shp_oe;
  } sba_state_t;

  localparam sba_state_t STATE_RST = '{
    ten: SBA_IDLE, cfg: CFG_RST, sync1: '0, sync2: '0, int_req: '0, bus_o: '0,
    addr_oe: 1'b0, ctl_oe: 1'b0, im_ack: 1'b0, ext_hit: 1'b0, ext_snoop: 1'b0,
    ext_xfer: '0, shp_o: '0, shp_oe: '0};

  sba_state_t s_r;
  sba_state_t s_nxt;

  // Fold the synchronised pin levels onto the eight request lines.
  function automatic logic [IRQ_W-1:0] irq_map(input logic [RAW_W-1:0] raw,
                                               input sba_cfg_t          cfg);
    logic [DUP_W-1:0]    l1;
    logic [DUP_W-1:0]    l7;
    logic [SHARED_W-1:0] sh;
    logic [OTHER_W-1:0]  ot;
    logic [IRQ_W-1:0]    r;
    {ot, sh, l7, l1} = raw;
    r              = '0;
    r[LINE_DUP_A]  = |(l1 & cfg.line1_en);
    r[LINE_DUP_B]  = |(l7 & cfg.line7_en);
    r[LINE_SHP0]   = sh[0] & ~cfg.shp_baddr[0];
    r[LINE_SHP1]   = sh[1] & ~cfg.shp_baddr[1];
    r[LINE_SHP2]   = sh[2] & ~cfg.shp_baddr[2];
    r[LINE_OTHER0] = ot[0];
    r[LINE_OTHER1] = ot[1];
    r[LINE_OTHER2] = ot[2];
    return r;
  endfunction

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    return (a & HIT_MASK) == HIT_BASE;
  endfunction

  always_comb begin
    s_nxt           = s_r;
    s_nxt.im_ack    = 1'b0;
    s_nxt.ext_hit   = 1'b0;
    s_nxt.ext_snoop = 1'b0;
    if (cfg_wr) begin
      s_nxt.cfg = cfg_in;
    end
    // The first stage feeds only the second; the map looks at stage two.
    s_nxt.sync1   = {other_irq_i, shp_i, line7_pins_i, line1_pins_i};
    s_nxt.sync2   = s_r.sync1;
    s_nxt.int_req = irq_map(s_r.sync2, s_r.cfg);
    case (s_r.ten)
      SBA_IDLE: begin
        // A tenure is only taken while no external transfer starts, so the
        // block never fights an external master for the address pins.
        if (bus_mode_ext && im_start && !ext_start) begin
          s_nxt.ten    = SBA_OWN;
          s_nxt.bus_o  = im_xfer;
          s_nxt.im_ack = 1'b1;
        end
      end
      SBA_OWN: begin
        if (im_end) begin
          s_nxt.ten = SBA_IDLE;
        end
      end
      default: s_nxt.ten = SBA_IDLE;
    endcase
    // The memory controller only borrows the address pins; the control pins
    // stay released so that no one mistakes its cycles for a bus tenure.
    if (s_nxt.ten == SBA_OWN) begin
      s_nxt.addr_oe = 1'b1;
      s_nxt.ctl_oe  = 1'b1;
    end else if (!bus_mode_ext && mc_active) begin
      s_nxt.bus_o.addr = mc_addr;
      s_nxt.addr_oe    = 1'b1;
      s_nxt.ctl_oe     = 1'b0;
    end else begin
      s_nxt.addr_oe = 1'b0;
      s_nxt.ctl_oe  = 1'b0;
    end
    // An external start seen while we own the tenure is ignored rather than
    // flagged: arbitration sits outside this block and must prevent it.
    if (bus_mode_ext && ext_start && s_r.ten == SBA_IDLE) begin
      s_nxt.ext_xfer  = bus_i;
      s_nxt.ext_hit   = addr_hit(bus_i.addr);
      s_nxt.ext_snoop = bus_i.snoop_global_flag;
    end
    // Enables follow the next configuration so a pin turned into an input
    // is released in the same edge that reconfigures it.
    s_nxt.shp_oe = s_nxt.cfg.shp_baddr;
    s_nxt.shp_o  = mc_burst_addr & s_nxt.cfg.shp_baddr;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign im_ack    = s_r.im_ack;
  assign bus_o     = s_r.bus_o;
  assign addr_oe   = s_r.addr_oe;
  assign ctl_oe    = s_r.ctl_oe;
  assign ext_hit   = s_r.ext_hit;
  assign ext_snoop = s_r.ext_snoop;
  assign ext_xfer  = s_r.ext_xfer;
  assign shp_o     = s_r.shp_o;
  assign shp_oe    = s_r.shp_oe;
  assign int_req   = s_r.int_req;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  logic own;
  assign own = s_r.ten == SBA_OWN;

  reset_defaults_a: assert property (
    $rose(rstn) |-> s_r.cfg == CFG_RST && int_req == '0 && shp_oe == '0)
    else $error("routing not at default after reset");

  // Three held samples span both synchroniser stages and the output register.
  line1_path_a: assert property (
    (line1_pins_i[0] && s_r.cfg.line1_en[0] && !cfg_wr) [*3]
      |=> int_req[LINE_DUP_A])
    else $error("request line 1 not raised by its pin");

  shared_irq_path_a: assert property (
    (!shp_i[1] && !cfg_wr) [*3] |=> !int_req[LINE_SHP1])
    else $error("request line 3 raised without its pin");

  input_undriven_a: assert property (
    !s_r.cfg.shp_baddr[0] |-> !shp_oe[0])
    else $error("shared pin driven while an input");

  baddr_drive_a: assert property (
    s_r.cfg.shp_baddr[2] |-> shp_oe[2] && shp_o[2] == $past(mc_burst_addr[2]))
    else $error("burst address bit 31 not driven");

  own_addr_a: assert property (
    (bus_mode_ext && im_start && !ext_start && !own)
      |=> own && addr_oe && ctl_oe && im_ack && bus_o == $past(im_xfer))
    else $error("tenure not taken or address not driven");

  mc_addr_a: assert property (
    (!bus_mode_ext && mc_active && !own) |=> addr_oe && !ctl_oe
      && bus_o.addr == $past(mc_addr))
    else $error("memory address not on the address pins");

  kind_hold_a: assert property (
    (own && !im_end) |=> ctl_oe && $stable(bus_o.xfer_kind)
      && $stable(bus_o.xfer_byte_count) && $stable(bus_o.burst_flag))
    else $error("transfer type changed during tenure");

  global_release_a: assert property (
    (own && im_end) |=> !own && !ctl_oe)
    else $error("global flag driven after tenure");

  snoop_mark_a: assert property (
    (bus_mode_ext && ext_start && !own)
      |=> ext_snoop == $past(bus_i.snoop_global_flag) && ext_xfer == $past(bus_i))
    else $error("snoop marking wrong");

  // The global flag and the other control pins are only driven inside a
  // tenure of our own; an external initiator drives them otherwise.
  ctl_only_own_a: assert property (
    ctl_oe |-> own)
    else $error("control pins driven outside own tenure");

  ext_pulse_a: assert property (
    !(bus_mode_ext && ext_start && !own) |=> !ext_hit && !ext_snoop)
    else $error("decode pulse without an external start");

  hit_decode_a: assert property (
    (bus_mode_ext && ext_start && !own)
      |=> ext_hit == (($past(bus_i.addr) & HIT_MASK) == HIT_BASE))
    else $error("external address decoded wrongly");

  size_code_a: assert property (
    im_ack |-> bus_o.xfer_byte_count == $past(im_xfer.xfer_byte_count))
    else $error("transfer size not the requested one");

  burst_code_a: assert property (
    im_ack |-> bus_o.burst_flag == $past(im_xfer.burst_flag))
    else $error("burst flag not the requested one");

  int_mode_refuse_a: assert property (
    (!bus_mode_ext && !own) |=> !im_ack && !own)
    else $error("tenure taken in internal-master mode");

  addr_release_a: assert property (
    (bus_mode_ext && !own && !im_start) |=> !addr_oe && !own)
    else $error("address pins driven with no tenure");

  addr_hold_a: assert property (
    (own && !im_end) |=> addr_oe && $stable(bus_o.addr))
    else $error("address changed during tenure");

  global_hold_a: assert property (
    (own && !im_end) |=> $stable(bus_o.snoop_global_flag))
    else $error("global flag changed during tenure");

  line7_path_a: assert property (
    (line7_pins_i[1] && s_r.cfg.line7_en[1] && !cfg_wr) [*3]
      |=> int_req[LINE_DUP_B])
    else $error("request line 7 not raised by its second pin");

  other_path_a: assert property (
    other_irq_i[1] [*3] |=> int_req[LINE_OTHER1])
    else $error("request line 4 not raised by its pin");

  shp2_irq_a: assert property (
    (shp_i[2] && !s_r.cfg.shp_baddr[2] && !cfg_wr) [*3]
      |=> int_req[LINE_SHP2])
    else $error("request line 5 not raised by its shared pin");

  irq_quiet_a: assert property (
    (line1_pins_i == '0 && line7_pins_i == '0 && shp_i == '0 && other_irq_i == '0) [*3]
      |=> int_req == '0)
    else $error("request raised with all pins low");

  baddr_off_a: assert property (
    !s_r.cfg.shp_baddr[1] |-> !shp_o[1] && !shp_oe[1])
    else $error("shared pin driven while serving request line 3");

  cfg_load_a: assert property (
    cfg_wr |=> s_r.cfg == $past(cfg_in))
    else $error("routing not loaded");

  cfg_release_a: assert property (
    cfg_wr |=> shp_oe == $past(cfg_in.shp_baddr))
    else $error("pin enables lag the routing load");

endmodule

// [sba_pkg.sv]
package sba_pkg;

  localparam int ADDR_W   = 32;
  localparam int KIND_W   = 5;
  localparam int COUNT_W  = 4;
  localparam int IRQ_W    = 8;
  localparam int SHARED_W = 3;
  localparam int OTHER_W  = 3;
  localparam int DUP_W    = 2;

  // Line numbers of the interrupt request lines fed by pins.
  localparam int LINE_DUP_A   = 1;
  localparam int LINE_DUP_B   = 7;
  localparam int LINE_SHP0    = 2;
  localparam int LINE_SHP1    = 3;
  localparam int LINE_SHP2    = 5;
  localparam int LINE_OTHER0  = 0;
  localparam int LINE_OTHER1  = 4;
  localparam int LINE_OTHER2  = 6;

  // Synchroniser depth plus output register: pin to int_req latency.
  localparam int IRQ_LAT = 3;

  typedef struct packed {
    logic [ADDR_W-1:0]  addr;
    logic [KIND_W-1:0]  xfer_kind;
    logic [COUNT_W-1:0] xfer_byte_count;
    logic               burst_flag;
    logic               snoop_global_flag;
  } sba_xfer_t;

  // Pin routing: a set shp_baddr bit makes that shared pin a burst
  // address output, a clear bit makes it an interrupt input.
  typedef struct packed {
    logic [SHARED_W-1:0] shp_baddr;
    logic [DUP_W-1:0]    line1_en;
    logic [DUP_W-1:0]    line7_en;
  } sba_cfg_t;

  localparam sba_cfg_t CFG_RST = '{shp_baddr: 3'h0, line1_en: 2'h3, line7_en: 2'h3};

  typedef enum logic {SBA_IDLE, SBA_OWN} sba_ten_t;

endpackage

// [sba_ext_master.sv]
`timescale 1ns/10ps
// Stands in for one external master driving the address-phase pins.
module sba_ext_master
  import sba_pkg::*;
(
  input  wire logic ref_clk,
  output logic      ext_start,
  output sba_xfer_t bus_i
);
  initial begin
    ext_start = 1'b0;
    bus_i     = '0;
  end
  // Called just after an edge; a released bus shows the inverse so a stale sample cannot pass.
  task automatic send(input sba_xfer_t x, input int gap);
    repeat (gap) begin
      @(posedge ref_clk);
      #1;
    end
    bus_i     = x;
    ext_start = 1'b1;
    @(posedge ref_clk);
    #1;
    ext_start = 1'b0;
    bus_i     = ~x;
  endtask
endmodule

// [sba_addr_phase_bench.sv]
`timescale 1ns/10ps
module sba_addr_phase_bench;
  import sba_pkg::*;
  logic                ref_clk, rstn, bus_mode_ext, cfg_wr, im_start, im_end, im_ack;
  logic                mc_active, ext_start, addr_oe, ctl_oe, ext_hit, ext_snoop;
  sba_cfg_t            cfg_in;
  sba_xfer_t           im_xfer, bus_i, bus_o, ext_xfer;
  logic [ADDR_W-1:0]   mc_addr;
  logic [SHARED_W-1:0] mc_burst_addr, shp_i, shp_o, shp_oe;
  logic [DUP_W-1:0]    line1_pins_i, line7_pins_i;
  logic [OTHER_W-1:0]  other_irq_i;
  logic [IRQ_W-1:0]    int_req;
  int                  n_fail, checked;

  sba_addr_phase dut (.ref_clk(ref_clk), .rstn(rstn), .bus_mode_ext(bus_mode_ext),
    .cfg_wr(cfg_wr), .cfg_in(cfg_in), .im_start(im_start), .im_xfer(im_xfer),
    .im_end(im_end), .im_ack(im_ack), .mc_active(mc_active), .mc_addr(mc_addr),
    .mc_burst_addr(mc_burst_addr), .ext_start(ext_start), .bus_i(bus_i), .bus_o(bus_o),
    .addr_oe(addr_oe), .ctl_oe(ctl_oe), .ext_hit(ext_hit), .ext_snoop(ext_snoop),
    .ext_xfer(ext_xfer), .line1_pins_i(line1_pins_i), .line7_pins_i(line7_pins_i),
    .shp_i(shp_i), .shp_o(shp_o), .shp_oe(shp_oe), .other_irq_i(other_irq_i),
    .int_req(int_req));
  sba_ext_master ext (.ref_clk(ref_clk), .ext_start(ext_start), .bus_i(bus_i));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check_b(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic check_v(input string nm, input logic [42:0] e, input logic [42:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic print_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic t_reset;
    check_v("shp_oe", 3'h0, shp_oe);
    line1_pins_i = 2'h1;
    line7_pins_i = 2'h2;
    other_irq_i  = 3'h5;
    tick(2);
    check_v("int_req", 8'h00, int_req);
    tick(1);
    check_v("int_req", 8'hC3, int_req);
    line1_pins_i = 2'h2;
    line7_pins_i = 2'h1;
    other_irq_i  = 3'h2;
    tick(3);
    check_v("int_req", 8'h92, int_req);
    line1_pins_i = 2'h0;
    line7_pins_i = 2'h0;
    other_irq_i  = 3'h0;
    tick(3);
    check_v("int_req", 8'h00, int_req);
    $display("test reset done");
  endtask

  task automatic t_own;
    bus_mode_ext = 1'b1;
    im_xfer  = '{addr: 32'h1234_5678, xfer_kind: 5'h0A, xfer_byte_count: 4'h8,
                 burst_flag: 1'b1, snoop_global_flag: 1'b1};
    im_start = 1'b1;
    tick(1);
    im_start = 1'b0;
    check_b("im_ack", 1'b1, im_ack);
    check_v("bus_o", im_xfer, bus_o);
    check_b("ctl_oe", 1'b1, ctl_oe);
    tick(1);
    check_b("im_ack", 1'b0, im_ack);
    check_b("addr_oe", 1'b1, addr_oe);
    im_end = 1'b1;
    tick(1);
    im_end = 1'b0;
    check_b("ctl_oe", 1'b0, ctl_oe);
    check_b("addr_oe", 1'b0, addr_oe);
    $display("test own tenure done");
  endtask

  task automatic t_ext;
    sba_xfer_t x;
    x = '{addr: 32'h0001_0040, xfer_kind: 5'h02, xfer_byte_count: 4'h4,
          burst_flag: 1'b0, snoop_global_flag: 1'b1};
    ext.send(x, 0);
    check_b("ext_hit", 1'b1, ext_hit);
    check_b("ext_snoop", 1'b1, ext_snoop);
    check_v("ext_xfer", x, ext_xfer);
    x = '{addr: 32'h8000_0000, xfer_kind: 5'h12, xfer_byte_count: 4'h0,
          burst_flag: 1'b1, snoop_global_flag: 1'b0};
    ext.send(x, 2);
    check_b("ext_hit", 1'b0, ext_hit);
    check_b("ext_snoop", 1'b0, ext_snoop);
    $display("test external decode done");
  endtask

  task automatic t_mc;
    bus_mode_ext = 1'b0;
    mc_active    = 1'b1;
    mc_addr      = 32'hCAFE_0010;
    im_start     = 1'b1;
    tick(1);
    im_start = 1'b0;
    check_b("im_ack", 1'b0, im_ack);
    check_b("addr_oe", 1'b1, addr_oe);
    check_b("ctl_oe", 1'b0, ctl_oe);
    check_v("bus_o.addr", 32'hCAFE_0010, bus_o.addr);
    mc_active = 1'b0;
    tick(1);
    $display("test memory controller done");
  endtask

  task automatic t_cfg;
    mc_burst_addr = 3'h7;
    cfg_in = '{shp_baddr: 3'h5, line1_en: 2'h1, line7_en: 2'h3};
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
    check_v("shp_oe", 3'h5, shp_oe);
    tick(1);
    check_v("shp_o", 3'h5, shp_o);
    line1_pins_i = 2'h2;
    shp_i        = 3'h7;
    tick(3);
    check_v("int_req", 8'h08, int_req);
    $display("test pin routing done");
  endtask

  // Routing loaded earlier must fall back to the default on a second reset.
  task automatic t_rerun;
    rstn = 1'b0;
    tick(1);
    rstn = 1'b1;
    check_v("shp_oe", 3'h0, shp_oe);
    check_v("int_req", 8'h00, int_req);
    tick(3);
    check_v("int_req", 8'h2E, int_req);
    tick(1);
    $display("test reset in mid-run done");
  endtask

  initial begin
    {rstn, bus_mode_ext, cfg_wr, im_start, im_end, mc_active} = '0;
    cfg_in = '0;
    im_xfer = '0;
    mc_addr = '0;
    {mc_burst_addr, shp_i, line1_pins_i, line7_pins_i, other_irq_i} = '0;
    n_fail  = 0;
    checked = 0;
    tick(4);
    rstn = 1'b1;
    t_reset();
    t_own();
    t_ext();
    t_mc();
    t_cfg();
    t_rerun();
    print_verdict();
  end

  // The tests need well under a hundred cycles; this span only catches a hang.
  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end
endmodule
